/* File: rtl/ief_top.sv */
// interrupt enable register, contactless error flags and the interrupt
// pin driver; assumes all event inputs come from logic on CLK and that
// the pin wire is resolved outside from IRQ_O and IRQ_OE_N
//
// Operation
// - enable bit 7 high drives the pin push-pull, low open-drain.
// - combined request reaches the pin only while enable bit 6 is set.
// - card-detect request joins the combined request only with bit 5.
// - timer requests 4..0 join only with their enable bits 4..0.
// - error bit 7 reflects failure of the latest nonvolatile command.
// - FIFO writes during CRC, receive states or authentication set bit 6.
// - bit 6 clears on command start, or after errors stored in multi-frame.
// - write to full FIFO sets bit 5; later writes dropped while set.
// - valid start then fewer than 4 data bits sets bit 4.
// - short frames are dropped silently, decoder kept on, no receive request.
// - bits 4,2,1,0 clear at receive start or transceive wait-for-data entry.
// - transmission started with empty FIFO sets bit 3.
// - collision sets bit 2 and records first collision position if below 64.
// - collision inside end-of-frame symbol does not set bit 2.
// - stop bit, type-B framing or byte count fault sets bit 1, stops receive.
// - on protocol error the last received byte is not stored.
// - parity or CRC mismatch sets bit 0, reception continues.
// - with collision-as-error set, a collision also sets bit 0.
// - error request is high while any of bits 6,5,3,1,0 is set.
// - combined request is high while any enabled request is active.
// - pin polarity bit inverts the level on the pin.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
module ief_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic CARD_REQ,
  input wire logic [4:0] TMR_REQ,
  input wire logic OTHER_REQ,
  input wire logic PIN_INVERT,
  input wire ief_pkg::ief_nvm_s NVM,
  input wire ief_pkg::ief_cmd_s CMD,
  input wire ief_pkg::ief_rx_s RX,
  input wire logic FIFO_WR,
  input wire logic FIFO_FULL,
  output logic FIFO_WR_ACCEPT,
  output logic RX_DONE_REQ,
  output logic RX_DISCARD,
  output logic RX_STOP,
  output logic DROP_LAST_BYTE,
  output logic ERR_REQ,
  output logic COMBINED_REQ,
  output logic IRQ_O,
  output logic IRQ_OE_N
);
  import ief_pkg::*;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // one wait cycle: read data is captured on the first cycle of the
  // request and the write lands at the edge that sees waitrequest low
  logic wait_q;
  logic wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0] rd_mux;
  logic [5:0] idx;
  logic wr_en;
  logic [7:0] en_q;
  logic [7:0] en_d;
  logic [7:0] err_q;
  logic [7:0] err_d;
  logic [7:0] coll_q;
  logic [7:0] coll_d;
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic comb_q;
  logic comb_d;
  logic ereq_q;
  logic ereq_d;

  assign idx = AVS_ADDRESS[7:2];
  assign wr_en = AVS_WRITE && !wait_q && AVS_BYTEENABLE[0];

  always_comb begin
    case (idx)
      IDX_EN: rd_mux = en_q;
      IDX_ERR: rd_mux = err_q;
      IDX_COLL: rd_mux = coll_q;
      IDX_CTRL: rd_mux = {5'h00, ctrl_q};
      IDX_STAT: rd_mux = {comb_q, ereq_q, CARD_REQ, TMR_REQ};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if ((AVS_READ || AVS_WRITE) && wait_q) begin
      wait_d = 1'b0;
      rdata_d = 32'h0000_0000;
      if (AVS_READ) begin
        rdata_d = {24'h00_0000, rd_mux};
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA = rdata_q;

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // the error register has no write path at all
  always_comb begin
    en_d = en_q;
    ctrl_d = ctrl_q;
    if (wr_en && idx == IDX_EN) begin
      en_d = AVS_WRITEDATA[7:0];
    end
    if (wr_en && idx == IDX_CTRL) begin
      ctrl_d = AVS_WRITEDATA[2:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      en_q <= EN_RST;
      ctrl_q <= CTRL_RST;
    end else begin
      en_q <= en_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------------------------------------------------------
  // error flags
  // ---------------------------------------------------------------
  ief_com_e com_q;
  logic rx_clr;
  logic fwr_clr;
  logic fwr_bad;
  logic rx_busy;
  logic coll_hit;
  logic coll_first;
  logic short_frm;
  logic suppr_frm;

  assign rx_busy = (CMD.com_state == COM_RECEIVE_WAIT_STATE) ||
                   (CMD.com_state == COM_WAITDATA) ||
                   (CMD.com_state == COM_RX);
  assign fwr_bad = FIFO_WR && (CMD.crc_tx || rx_busy || CMD.auth);
  assign fwr_clr = CMD.start || (ctrl_q[CT_MULTI] && CMD.err_stored);
  assign rx_clr = CMD.recv_start || (CMD.transceive &&
                  CMD.com_state == COM_WAITDATA &&
                  com_q != COM_WAITDATA);
  assign coll_hit = RX.coll && !RX.coll_eof;
  assign coll_first = rx_clr || !err_q[ER_COLL];
  assign short_frm = RX.frame_end && RX.frame_bits < MIN_FRAME_BITS;
  assign suppr_frm = RX.frame_end && ctrl_q[CT_SUPPR] &&
                     RX.frame_bits < SUPPR_MIN_BITS;

  // clears first, sets after, so an event in a clearing cycle survives
  always_comb begin
    err_d = err_q;
    coll_d = coll_q;
    if (NVM.done) begin
      err_d[ER_NVM] = NVM.fail;
    end
    if (fwr_clr) begin
      err_d[ER_FWR] = 1'b0;
    end
    if (CMD.fifo_flush) begin
      err_d[ER_OVF] = 1'b0;
    end
    if (CMD.start) begin
      err_d[ER_EMPTY] = 1'b0;
    end
    if (rx_clr) begin
      err_d[ER_SHORT] = 1'b0;
      err_d[ER_COLL] = 1'b0;
      err_d[ER_PROT] = 1'b0;
      err_d[ER_INTEG] = 1'b0;
      coll_d = COLL_RST;
    end
    if (fwr_bad) begin
      err_d[ER_FWR] = 1'b1;
    end
    if (FIFO_WR && FIFO_FULL) begin
      err_d[ER_OVF] = 1'b1;
    end
    if (short_frm) begin
      err_d[ER_SHORT] = 1'b1;
    end
    if (CMD.tx_start && CMD.fifo_empty) begin
      err_d[ER_EMPTY] = 1'b1;
    end
    if (coll_hit) begin
      err_d[ER_COLL] = 1'b1;
      if (coll_first) begin
        // only the first 8 bytes have a position to show
        if (RX.coll_pos < COLL_POS_LIMIT) begin
          coll_d = {1'b1, RX.coll_pos[6:0]};
        end else begin
          coll_d = COLL_RST;
        end
      end
      if (ctrl_q[CT_COLL_ERR]) begin
        err_d[ER_INTEG] = 1'b1;
      end
    end
    if (RX.prot_err) begin
      err_d[ER_PROT] = 1'b1;
    end
    if (RX.integ_err) begin
      err_d[ER_INTEG] = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      err_q <= ERR_RST;
      coll_q <= COLL_RST;
      com_q <= COM_IDLE;
    end else begin
      err_q <= err_d;
      coll_q <= coll_d;
      com_q <= CMD.com_state;
    end
  end

  // ---------------------------------------------------------------
  // FIFO and receiver steering
  // ---------------------------------------------------------------
  logic acc_q;
  logic acc_d;
  logic done_q;
  logic done_d;
  logic disc_q;
  logic disc_d;
  logic stop_q;
  logic stop_d;

  always_comb begin
    // contents stay untouched once overflow is flagged
    acc_d = FIFO_WR && !FIFO_FULL && !err_q[ER_OVF];
    // decoder is never stopped for a short frame, only for protocol faults
    disc_d = short_frm || suppr_frm;
    done_d = RX.frame_end && !disc_d;
    stop_d = RX.prot_err;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      acc_q <= 1'b0;
      done_q <= 1'b0;
      disc_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      done_q <= done_d;
      disc_q <= disc_d;
      stop_q <= stop_d;
    end
  end

  assign FIFO_WR_ACCEPT = acc_q;
  assign RX_DONE_REQ = done_q;
  assign RX_DISCARD = disc_q;
  assign RX_STOP = stop_q;
  assign DROP_LAST_BYTE = stop_q;

  // ---------------------------------------------------------------
  // request combining and pin driver
  // ---------------------------------------------------------------
  logic pin_lvl;
  logic irq_q;
  logic irq_d;
  logic oen_q;
  logic oen_d;

  always_comb begin
    ereq_d = err_d[ER_FWR] || err_d[ER_OVF] || err_d[ER_PROT] ||
             err_d[ER_EMPTY] || err_d[ER_INTEG];
    comb_d = OTHER_REQ ||
             (CARD_REQ && en_q[EN_CARD]) ||
             (|(TMR_REQ & en_q[EN_TMR_HI:0]));
    pin_lvl = comb_d && en_q[EN_PINOUT];
    if (en_q[EN_PUSHPULL]) begin
      irq_d = pin_lvl ^ PIN_INVERT;
      oen_d = 1'b0;
    end else begin
      // open drain: only the active level is ever driven
      irq_d = !PIN_INVERT;
      oen_d = !pin_lvl;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ereq_q <= 1'b0;
      comb_q <= 1'b0;
      irq_q <= 1'b0;
      oen_q <= 1'b1;
    end else begin
      ereq_q <= ereq_d;
      comb_q <= comb_d;
      irq_q <= irq_d;
      oen_q <= oen_d;
    end
  end

  assign ERR_REQ = ereq_q;
  assign COMBINED_REQ = comb_q;
  assign IRQ_O = irq_q;
  assign IRQ_OE_N = oen_q;
endmodule

/* File: rtl/ief_pkg.sv */
// constants, field positions and carriers for the interrupt enable and
// contactless error flag block; assumes one 250 MHz system clock
package ief_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_EN = 6'h09;
  localparam logic [5:0] IDX_ERR = 6'h0A;
  localparam logic [5:0] IDX_COLL = 6'h0D;
  localparam logic [5:0] IDX_CTRL = 6'h10;
  localparam logic [5:0] IDX_STAT = 6'h11;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] ERR_RST = 8'h00;
  localparam logic [7:0] COLL_RST = 8'h00;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // ---------------------------------------------------------------
  // enable register fields
  // ---------------------------------------------------------------
  localparam int EN_PUSHPULL = 7;
  localparam int EN_PINOUT = 6;
  localparam int EN_CARD = 5;
  localparam int EN_TMR_HI = 4;
  localparam int NUM_TMR = 5;
  // ---------------------------------------------------------------
  // error register fields
  // ---------------------------------------------------------------
  localparam int ER_NVM = 7;
  localparam int ER_FWR = 6;
  localparam int ER_OVF = 5;
  localparam int ER_SHORT = 4;
  localparam int ER_EMPTY = 3;
  localparam int ER_COLL = 2;
  localparam int ER_PROT = 1;
  localparam int ER_INTEG = 0;
  // ---------------------------------------------------------------
  // control and collision position fields
  // ---------------------------------------------------------------
  localparam int CT_COLL_ERR = 0;
  localparam int CT_MULTI = 1;
  localparam int CT_SUPPR = 2;
  localparam int CP_VALID = 7;
  // ---------------------------------------------------------------
  // frame limits in data bits
  // ---------------------------------------------------------------
  localparam logic [15:0] MIN_FRAME_BITS = 16'h0004;
  localparam logic [15:0] SUPPR_MIN_BITS = 16'h0018;
  localparam logic [15:0] COLL_POS_LIMIT = 16'h0040;
  // ---------------------------------------------------------------
  // transceiver state as reported by the sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    COM_IDLE = 3'h0,
    COM_TXWAIT = 3'h1,
    COM_TX = 3'h3,
    COM_RECEIVE_WAIT_STATE = 3'h5,
    COM_WAITDATA = 3'h6,
    COM_RX = 3'h7
  } ief_com_e;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic recv_start;
    logic transceive;
    logic fifo_flush;
    logic err_stored;
    logic tx_start;
    logic fifo_empty;
    logic crc_tx;
    logic auth;
    ief_com_e com_state;
  } ief_cmd_s;
  typedef struct packed {
    logic frame_end;
    logic [15:0] frame_bits;
    logic coll;
    logic coll_eof;
    logic [15:0] coll_pos;
    logic prot_err;
    logic integ_err;
  } ief_rx_s;
  typedef struct packed {
    logic done;
    logic fail;
  } ief_nvm_s;
endpackage

/* File: sim/ief_top_sva.sv */
// checker: request, pin and error-flag timing at the ports of ief_top
// assumes one clock CLK and the active-high reset RST of the design
`timescale 1ns/1ps
module ief_top_sva (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CARD_REQ,
  input wire logic [4:0] TMR_REQ,
  input wire logic OTHER_REQ,
  input wire logic PIN_INVERT,
  input wire ief_pkg::ief_cmd_s CMD,
  input wire ief_pkg::ief_rx_s RX,
  input wire logic FIFO_WR,
  input wire logic FIFO_FULL,
  input wire logic FIFO_WR_ACCEPT,
  input wire logic RX_DONE_REQ,
  input wire logic RX_DISCARD,
  input wire logic RX_STOP,
  input wire logic DROP_LAST_BYTE,
  input wire logic ERR_REQ,
  input wire logic COMBINED_REQ,
  input wire logic IRQ_O,
  input wire logic IRQ_OE_N
);
  import ief_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_prot_stop: assert property (RX.prot_err |=> RX_STOP && DROP_LAST_BYTE)
    else $error("protocol error did not stop reception");
  a_integ_flag: assert property (RX.integ_err |=> ERR_REQ)
    else $error("integrity error raised no error request");
  a_fifo_wrerr: assert property (FIFO_WR && CMD.com_state == COM_RX |=> ERR_REQ)
    else $error("write while receiving raised no error request");
  a_ovf_drop: assert property (FIFO_WR && FIFO_FULL |=> !FIFO_WR_ACCEPT && ERR_REQ)
    else $error("write to full fifo was accepted");
  a_short_drop: assert property (RX.frame_end && RX.frame_bits < MIN_FRAME_BITS
    |=> RX_DISCARD && !RX_DONE_REQ)
    else $error("short frame was not discarded");
  a_long_keep: assert property (RX.frame_end && RX.frame_bits >= SUPPR_MIN_BITS
    |=> RX_DONE_REQ && !RX_DISCARD)
    else $error("long frame was discarded");
  a_comb_cause: assert property (COMBINED_REQ |->
    $past(CARD_REQ || (|TMR_REQ) || OTHER_REQ))
    else $error("combined request without a request");
  a_pin_active: assert property (!IRQ_OE_N && IRQ_O != $past(PIN_INVERT) |->
    COMBINED_REQ)
    else $error("pin active without combined request");
  c_prot: cover property (RX.prot_err ##1 RX_STOP);
  c_short: cover property (RX.frame_end ##1 RX_DISCARD);
  c_pin: cover property (COMBINED_REQ && !IRQ_OE_N);
  c_keep: cover property (RX.frame_end ##1 RX_DONE_REQ);
endmodule

bind ief_top ief_top_sva u_sva (.CLK, .RST, .CARD_REQ, .TMR_REQ, .OTHER_REQ, .PIN_INVERT,
  .CMD, .RX, .FIFO_WR, .FIFO_FULL, .FIFO_WR_ACCEPT, .RX_DONE_REQ, .RX_DISCARD, .RX_STOP,
  .DROP_LAST_BYTE, .ERR_REQ, .COMBINED_REQ, .IRQ_O, .IRQ_OE_N);

/* File: sim/ief_host.sv */
// host model: register bus master and the pulled-up interrupt line
// assumes the bench calls xfer only after reset is released
`timescale 1ns/1ps
module ief_host (
  input wire logic clk,
  input wire logic wreq,
  input wire logic [31:0] rdat,
  input wire logic io,
  input wire logic ioe_n,
  output logic [7:0] adr,
  output logic rd,
  output logic wr,
  output logic [31:0] wdat,
  output logic line
);
  // a released pin reads as the pull-up level
  assign line = ioe_n ? 1'b1 : io;
  initial begin
    adr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h00000000;
  end
  // error flags are read back as status; one write of all ones checks they stay clear
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    adr <= a;
    wdat <= {24'h000000, d};
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
endmodule

/* File: sim/tb_irq_enable_and_rx_error_flags.sv */
// bench for ief_top: registers, request masking, pin modes, error flags
// assumes the host model drives the register bus and resolves the pin
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module tb_irq_enable_and_rx_error_flags;
  import ief_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic card = 1'b0;
  logic oth = 1'b0;
  logic [4:0] tmr = 5'h00;
  logic inv = 1'b0;
  logic fwr = 1'b0;
  logic full = 1'b0;
  ief_nvm_s nvm = '0;
  ief_cmd_s cmd = '0;
  ief_rx_s rx = '0;
  logic [7:0] adr, q;
  logic rds, wrs, wreq, acc, rxd, disc, stp, dlb, ereq, creq, io, ioe, line;
  logic [31:0] wdat, rdat;
  int n_mismatch = 0;
  int checks_done = 0;
  always #2 clk = ~clk;
  ief_top DUT (.CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rds), .AVS_WRITE(wrs),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .CARD_REQ(card), .TMR_REQ(tmr), .OTHER_REQ(oth), .PIN_INVERT(inv), .NVM(nvm), .CMD(cmd),
    .RX(rx), .FIFO_WR(fwr), .FIFO_FULL(full), .FIFO_WR_ACCEPT(acc), .RX_DONE_REQ(rxd),
    .RX_DISCARD(disc), .RX_STOP(stp), .DROP_LAST_BYTE(dlb), .ERR_REQ(ereq),
    .COMBINED_REQ(creq), .IRQ_O(io), .IRQ_OE_N(ioe));
  ief_host host (.clk(clk), .wreq(wreq), .rdat(rdat), .io(io), .ioe_n(ioe), .adr(adr),
    .rd(rds), .wr(wrs), .wdat(wdat), .line(line));
  // ---------------------------------------------------------------
  // helpers: one event pulse lasts exactly one edge
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic er(input logic [7:0] e);
    rd(8'h28);
    `CHK(q, e)
  endtask
  task automatic tick;
    @(posedge clk);
    cmd <= '0;
    rx <= '0;
    nvm <= '0;
    fwr <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rd(8'h24);
    `CHK(q, EN_RST)
    wr(8'h24, 8'hA5);
    rd(8'h25);
    `CHK(q, 8'hA5)
    wr(8'h28, 8'hFF);
    er(ERR_RST);
    rd(8'hFC);
    `CHK(q, 8'h00)
  endtask
  task automatic t_mask;
    logic [5:0] r;
    for (int i = 0; i < 6; i++) begin
      r = 6'h01 << i;
      wr(8'h24, {2'b01, r});
      {card, tmr} <= r;
      repeat (2) @(posedge clk);
      #1 `CHK(creq, 1'b1)
      wr(8'h24, {2'b01, ~r});
      repeat (2) @(posedge clk);
      #1 `CHK(creq, 1'b0)
      @(posedge clk);
      {card, tmr} <= 6'h00;
    end
    oth <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(creq, 1'b1)
    @(posedge clk);
    oth <= 1'b0;
  endtask
  task automatic t_pin;
    logic pp, pe;
    for (int k = 0; k < 8; k++) begin
      {pp, pe} = k[2:1];
      wr(8'h24, {pp, pe, 6'h20});
      card <= 1'b1;
      inv <= k[0];
      repeat (2) @(posedge clk);
      #1;
      if (pp) begin
        `CHK(ioe, 1'b0)
        `CHK(line, pe ^ inv)
      end else begin
        `CHK(ioe, !pe)
        `CHK(io, !inv)
      end
      @(posedge clk);
      card <= 1'b0;
      repeat (2) @(posedge clk);
      #1 `CHK(ioe, !pp)
    end
  endtask
  task automatic t_fifo;
    @(posedge clk);
    fwr <= 1'b1;
    cmd.com_state <= COM_RX;
    tick;
    #1 `CHK(ereq, 1'b1)
    er(8'h40);
    cmd.start <= 1'b1;
    tick;
    er(8'h00);
    wr(8'h40, 8'h02);
    fwr <= 1'b1;
    cmd.crc_tx <= 1'b1;
    tick;
    @(posedge clk);
    cmd.err_stored <= 1'b1;
    tick;
    er(8'h00);
    fwr <= 1'b1;
    full <= 1'b1;
    tick;
    @(posedge clk);
    full <= 1'b0;
    fwr <= 1'b1;
    tick;
    #1 `CHK(acc, 1'b0)
    er(8'h20);
    cmd.fifo_flush <= 1'b1;
    tick;
    @(posedge clk);
    fwr <= 1'b1;
    tick;
    #1 `CHK(acc, 1'b1)
  endtask
  task automatic t_flags;
    @(posedge clk);
    nvm <= 2'b11;
    tick;
    @(posedge clk);
    cmd.tx_start <= 1'b1;
    cmd.fifo_empty <= 1'b1;
    tick;
    er(8'h88);
    wr(8'h40, 8'h04);
    rx.frame_end <= 1'b1;
    rx.frame_bits <= 16'h0003;
    tick;
    #1 `CHK(disc, 1'b1)
    @(posedge clk);
    rx.frame_end <= 1'b1;
    rx.frame_bits <= 16'h0010;
    tick;
    #1 `CHK(disc, 1'b1)
    `CHK(rxd, 1'b0)
    @(posedge clk);
    rx.frame_end <= 1'b1;
    rx.frame_bits <= 16'h0020;
    tick;
    #1 `CHK(rxd, 1'b1)
    `CHK(disc, 1'b0)
    @(posedge clk);
    rx.prot_err <= 1'b1;
    rx.integ_err <= 1'b1;
    tick;
    #1 `CHK(stp, 1'b1)
    `CHK(dlb, 1'b1)
    er(8'h9B);
    cmd.recv_start <= 1'b1;
    nvm <= 2'b10;
    tick;
    er(8'h08);
    rx.coll <= 1'b1;
    rx.coll_pos <= 16'h0005;
    tick;
    rd(8'h34);
    `CHK(q, 8'h85)
    cmd.transceive <= 1'b1;
    cmd.com_state <= COM_WAITDATA;
    tick;
    wr(8'h40, 8'h01);
    rx.coll <= 1'b1;
    rx.coll_eof <= 1'b1;
    tick;
    er(8'h08);
    rx.coll <= 1'b1;
    tick;
    er(8'h0D);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    summarize;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_mask;
    t_pin;
    t_fifo;
    t_flags;
    summarize;
  end
endmodule
